// ### bench/coproc_error_model.sv
// Numeric coprocessor error line model.
// Assumes fail_i and clear_i change just after a clock edge.
`timescale 1ns/100ps
module coproc_error_model #(
   parameter int LAG = 2  // Cycles from failure to pin
) (
   input  wire logic clk_i,     // Clock
   input  wire logic rst_i,     // Sync reset
   input  wire logic fail_i,    // Failing operation
   input  wire logic clear_i,   // Exceptions cleared
   output logic      error_n_o  // Error pin, low
);
   int lag_q;
   // Pin stays low until cleared, as a real coprocessor keeps it
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         lag_q <= 0;
         error_n_o <= 1'b1;
      end else if (fail_i) begin
         lag_q <= LAG;
      end else if (lag_q == 1) begin
         lag_q <= 0;
         error_n_o <= 1'b0;
      end else if (lag_q > 1) begin
         lag_q <= lag_q - 1;
      end
   end
endmodule

// ### bench/prot_exc_properties.sv
// Checker of the protection exception unit.
// Bound to the unit; sees only its ports.
`timescale 1ns/100ps
module prot_exc_checker (
   input  wire logic        clk_i,         // Clock
   input  wire logic        rst_i,         // Sync reset
   input  wire logic        wb_cyc_i,      // Cycle
   input  wire logic        wb_stb_i,      // Strobe
   input  wire logic        wb_ack_o,      // Acknowledge
   input  wire logic        ref_valid_i,   // Reference
   input  wire logic        ref_word_i,    // Word access
   input  wire logic [15:0] ref_offset_i,  // Offset
   input  wire logic        fault_valid_i, // Core fault
   input  wire logic [15:0] handler_sp_i,  // Handler stack
   input  wire logic        push_ready_i,  // Push taken
   input  wire logic        push_o,        // Push request
   input  wire logic [15:0] push_addr_o,   // Push offset
   input  wire logic        enter_o,       // Entry pulse
   input  wire logic [7:0]  vector_o,      // Vector
   input  wire logic        busy_o         // Busy
);
   logic [15:0] last_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_q <= 16'h0000;
      end else if (push_o && push_ready_i) begin
         last_q <= push_addr_o;
      end
   end
   a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_push_held: assert property (
      push_o && !push_ready_i && !fault_valid_i |=> push_o && $stable(push_addr_o))
      else $error("push dropped or moved before taken");
   a_enter_one_pulse: assert property (enter_o |=> !enter_o)
      else $error("entry pulse too long");
   a_vector_fixed: assert property (
      enter_o |-> vector_o inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
                                   8'h0D, 8'h10})
      else $error("vector outside the fixed slots");
   a_push_step_down: assert property (
      (push_o && push_ready_i && !fault_valid_i) ##1 push_o
      |-> push_addr_o == $past(push_addr_o) - 16'h0002)
      else $error("stack pushes not two bytes apart");
   a_code_last_depth: assert property (
      enter_o |-> last_q == handler_sp_i -
         ((vector_o inside {8'h06, 8'h07, 8'h09, 8'h10}) ? 16'h0006 : 16'h0008))
      else $error("last push at wrong depth");
   a_word_top_fault: assert property (
      ref_valid_i && ref_word_i && ref_offset_i == 16'hFFFF && !busy_o && !enter_o &&
      !push_o |=> busy_o ##1 push_o)
      else $error("word at top offset not faulted");
   a_busy_ends_entry: assert property ($fell(busy_o) |-> enter_o)
      else $error("busy fell without entry");
endmodule

bind protection_exception_unit prot_exc_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .ref_valid_i, .ref_word_i, .ref_offset_i, .fault_valid_i, .handler_sp_i,
   .push_ready_i, .push_o, .push_addr_o, .enter_o, .vector_o, .busy_o);

// ### bench/protection_exception_unit_bench.sv
// Bench of the protection exception unit: bus, faults, references, numeric.
// Assumes package, unit, checker and error line model compiled first.
`timescale 1ns/100ps
module protection_exception_unit_bench;
   import prot_exc_pkg::*;
   logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o;
   logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o, rd;
   logic [3:0] wb_sel_i = 0;
   logic ref_valid_i = 0, ref_word_i = 0, ref_write_i = 0, ref_readonly_i = 0, ref_stack_i = 0;
   logic [15:0] ref_offset_i = 0, ref_limit_i = 0, ref_sel_i = 0, fault_sel_i = 0, sel;
   logic fault_valid_i = 0, fault_has_sel_i = 0, fault_desc_load_i = 0, fault_vectab_i = 0;
   logic ext_event_i = 0, num_start_i = 0, push_ready_i = 0, fail = 0, clr = 0, coproc_error_n_i;
   fault_kind_type fault_kind_i = FAULT_NONE;
   numeric_kind_type num_kind_i = NUM_NONE;
   logic [15:0] flags_i = 16'hA5C3, ret_cs_i = 16'h2010, ret_ip_i = 16'h0456;
   logic [15:0] handler_sp_i = 16'h0800, push_addr_o, push_data_o, pa[8], pd[8];
   logic push_o, enter_o, busy_o;
   logic [7:0] vector_o;
   int fail_count = 0, num_checks = 0, np = 0, n;
   fault_kind_type kinds[6] = '{FAULT_UNDEF, FAULT_TASK_STATE, FAULT_ABSENT, FAULT_STACK,
                                FAULT_GEN_PROT, FAULT_OVERRUN};
   logic [7:0] vecs[6] = '{8'h06, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h09};
   logic [3:0] ctls[3] = '{4'h3, 4'h5, 4'hD};

   always #5 clk_i = ~clk_i;
   protection_exception_unit DUT (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .ref_valid_i, .ref_offset_i, .ref_limit_i,
      .ref_word_i, .ref_write_i, .ref_readonly_i, .ref_stack_i, .ref_sel_i, .fault_valid_i,
      .fault_kind_i, .fault_has_sel_i, .fault_desc_load_i, .fault_sel_i, .fault_vectab_i,
      .ext_event_i, .num_kind_i, .num_start_i, .coproc_error_n_i, .flags_i, .ret_cs_i,
      .ret_ip_i, .handler_sp_i, .push_ready_i, .push_o, .push_addr_o, .push_data_o, .enter_o,
      .vector_o, .busy_o);
   coproc_error_model u_fpu (.clk_i, .rst_i, .fail_i(fail), .clear_i(clr),
      .error_n_o(coproc_error_n_i));

   // Stack memory stalls one cycle on every write
   always @(posedge clk_i) begin
      if (push_o === 1'b1 && push_ready_i === 1'b1 && np < 8) begin
         pa[np] = push_addr_o;
         pd[np] = push_data_o;
         np++;
      end
      push_ready_i <= push_o && !push_ready_i;
   end

   task check(input logic [31:0] got, exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task give_up(input string what);
      fail_count++;
      $display("mismatch at %0t: timeout %s", $time, what);
      stop_test;
   endtask
   task wb(input logic we, input logic [31:0] adr, dat);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, dat, 4'hF};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) give_up("bus");
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task pulse(input fault_kind_type k, input logic [15:0] s, input logic h, d, v, x);
      @(posedge clk_i);
      {fault_valid_i, fault_has_sel_i, fault_desc_load_i, fault_vectab_i} <= {1'b1, h, d, v};
      {fault_kind_i, fault_sel_i, ext_event_i} <= {k, s, x};
      @(posedge clk_i);
      np = 0;
      fault_valid_i <= 1'b0;
   endtask
   task ref_go(input logic [15:0] ofs, lim, s, input logic w, wr, ro);
      @(posedge clk_i);
      {ref_valid_i, ref_offset_i, ref_limit_i, ref_sel_i} <= {1'b1, ofs, lim, s};
      {ref_word_i, ref_write_i, ref_readonly_i} <= {w, wr, ro};
      @(posedge clk_i);
      np = 0;
      ref_valid_i <= 1'b0;
   endtask
   task num_go(input numeric_kind_type k);
      @(posedge clk_i);
      {num_start_i, num_kind_i} <= {1'b1, k};
      @(posedge clk_i);
      np = 0;
      num_start_i <= 1'b0;
   endtask
   task entry(input logic [7:0] vec, input logic [15:0] code, input int pushes);
      n = 0;
      while (enter_o !== 1'b1 && n < 60) begin
         @(posedge clk_i);
         n++;
      end
      if (enter_o !== 1'b1) give_up("entry");
      check(vector_o, vec, "vector");
      check(np, pushes, "push count");
      check(pd[0], flags_i, "frame flags");
      check({pd[1], pd[2]}, {ret_cs_i, ret_ip_i}, "frame pointer");
      check(pa[pushes-1], handler_sp_i - 16'(2 * pushes), "last slot");
      if (pushes == 4) check(pd[3], code, "error code");
      @(posedge clk_i);
   endtask
   task idle_check(input string what);
      repeat (6) @(posedge clk_i);
      check(busy_o, 1'b0, what);
      $display("test %s done", what);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 32'h0000_0000, 0);
      check(rd, 0, "control reset");
      wb(0, 32'h0000_0040, 0);
      check(rd, 0, "unmapped");
      wb(1, 32'h0000_0000, 1);
      wb(0, 32'h0000_0000, 0);
      check(rd, 1, "control");
      for (int i = 0; i < 6; i++) begin
         sel = 16'h1A28 + 16'(4 * i);
         pulse(kinds[i], sel, 1, 1, i == 2, i[0]);
         entry(vecs[i], {sel[15:3], i != 2 && sel[2], i == 2, i[0]}, vecs[i] < 10 ? 3 : 4);
      end
      wb(0, 32'h0000_0004, 0);
      check(rd[15:8], 8'h09, "status vector");
      pulse(FAULT_STACK, 16'h1A28, 0, 0, 0, 0);
      entry(8'h0C, 16'h0000, 4);
      pulse(FAULT_GEN_PROT, 16'h1A28, 1, 0, 0, 0);
      entry(8'h0D, 16'h0000, 4);
      ref_go(16'h0010, 16'h0010, 16'h0008, 1, 0, 0);
      entry(8'h0D, 16'h0000, 4);
      ref_go(16'h0000, 16'h00FF, 16'h0008, 0, 1, 1);
      entry(8'h0D, 16'h0000, 4);
      ref_go(16'h0000, 16'h00FF, 16'h0002, 0, 0, 0);
      entry(8'h0D, 16'h0000, 4);
      ref_go(16'h0000, 16'h00FF, 16'h0008, 1, 1, 0);
      idle_check("legal reference");
      // Null selector through the stack segment is not checked
      ref_stack_i <= 1'b1;
      ref_go(16'h0000, 16'h00FF, 16'h0002, 0, 0, 0);
      idle_check("stack null selector");
      ref_stack_i <= 1'b0;
      wb(1, 32'h0000_0000, 0);
      ref_go(16'hFFFF, 16'hFFFF, 16'h0008, 1, 0, 0);
      entry(8'h0D, 16'h0000, 4);
      wb(1, 32'h0000_0000, 1);
      @(posedge clk_i) fail <= 1'b1;
      @(posedge clk_i) fail <= 1'b0;
      repeat (6) @(posedge clk_i);
      num_go(NUM_CONTROL);
      idle_check("control numeric");
      num_go(NUM_TESTING);
      entry(8'h10, 16'h0000, 3);
      num_go(NUM_WAIT);
      entry(8'h10, 16'h0000, 3);
      for (int i = 0; i < 3; i++) begin
         wb(1, 32'h0000_0000, {28'h0, ctls[i]});
         num_go(i == 2 ? NUM_WAIT : NUM_TESTING);
         entry(8'h07, 16'h0000, 3);
      end
      @(posedge clk_i) clr <= 1'b1;
      @(posedge clk_i) clr <= 1'b0;
      pulse(FAULT_STACK, 16'h1A28, 1, 0, 0, 0);
      n = 0;
      while (!(push_o === 1'b1 && push_ready_i === 1'b0) && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      pulse(FAULT_GEN_PROT, 16'h1A28, 1, 1, 0, 0);
      entry(8'h08, 16'h0000, 4);
      $display("test faults done");
      stop_test;
   end
endmodule

// ### rtl/prot_exc_defines.svh
// Constants of the protection exception unit: vectors, error code fields, limits.
// Assumes inclusion by bare name from the package and the unit.
`ifndef PROT_EXC_DEFINES_SVH
`define PROT_EXC_DEFINES_SVH

`define VEC_UNDEF_OPCODE    8'h06
`define VEC_COPROC_UNAVAIL  8'h07
`define VEC_NESTED          8'h08
`define VEC_COPROC_OVERRUN  8'h09
`define VEC_BAD_TASK_STATE  8'h0A
`define VEC_SEG_ABSENT      8'h0B
`define VEC_STACK_FAULT     8'h0C
`define VEC_GEN_PROT        8'h0D
`define VEC_COPROC_ERROR    8'h10

`define ERR_EXT_BIT         0
`define ERR_VECTAB_BIT      1
`define ERR_LOCAL_BIT       2
`define ERR_INDEX_LSB       3
`define ERR_CODE_ZERO       16'h0000
`define NULL_SEL_MAX        16'h0003
`define REAL_WORD_LAST_OFS  16'hFFFF

// Bus register offsets, control reset value and control bits
`define REG_CONTROL         32'h0000_0000
`define REG_STATUS          32'h0000_0004
`define REG_LAST_CODE       32'h0000_0008
`define REG_FAULT_COUNT     32'h0000_000C
`define CONTROL_RESET       32'h0000_0000
`define CTL_PROT_BIT        0
`define CTL_EMU_BIT         1
`define CTL_TSW_BIT         2
`define CTL_MON_BIT         3

`endif

// ### rtl/prot_exc_pkg.sv
// Types of the protection exception unit.
// Assumes the defines header on the include path.
package prot_exc_pkg;
`include "prot_exc_defines.svh"

   typedef enum logic [3:0] {
      FAULT_NONE       = 4'b0000,
      FAULT_UNDEF      = 4'b0001,
      FAULT_TASK_STATE = 4'b0010,
      FAULT_ABSENT     = 4'b0011,
      FAULT_STACK      = 4'b0100,
      FAULT_GEN_PROT   = 4'b0101,
      FAULT_OVERRUN    = 4'b0110
   } fault_kind_type;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_PUSH_FL  = 3'b001,
      ST_PUSH_CS  = 3'b010,
      ST_PUSH_IP  = 3'b011,
      ST_PUSH_ERR = 3'b100,
      ST_ENTER    = 3'b101
   } exc_state_type;

   // Numeric operation classes; NUM_CONTROL and NUM_NONE never look at the error line
   typedef enum logic [1:0] {
      NUM_NONE    = 2'b00,
      NUM_TESTING = 2'b01,
      NUM_CONTROL = 2'b10,
      NUM_WAIT    = 2'b11
   } numeric_kind_type;
endpackage

// ### rtl/protection_exception_unit.sv
// Protection exception unit: checks references, picks a vector, builds and
// pushes the error code. Assumes the core stalls while busy_o is high and
// presents its stack pointer already switched for the handler level.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "prot_exc_defines.svh"

// How it works
// - In protected mode every reference is checked; violations start handler entry.
// - Each fault kind maps onto its fixed vector number.
// - Faults with an error code push a 16-bit code last.
// - Pushes use the handler stack pointer given by the core.
// - Bit 0 of a selector code set when fault arose while servicing an external event.
// - Vector table selector sets bit 1; bits 3-15 hold its index.
// - Descriptor table selector clears bit 1; bit 2 marks local table.
// - With no selector information the pushed code is all zero.
// - A fault during handler entry raises the nested fault, zero code.
// - Faults inside a handler body take their ordinary vector.
// - Nested fault saves the pointer of the executing instruction.
// - Uncovered violations such as limit or write faults raise vector 13.
// - General protection pushes the selector only on descriptor loads.
// - Use of a selector 0 to 3 outside the stack segment raises general protection, zero code.
// - Real mode word access at offset FFFF raises 13, zero code.
// - Error line sampled on most numeric instructions and on non-emulated wait.
// - Control-type numeric operations do not sample the error line.
// - Coprocessor error reported at the following numeric instruction.
// - Coprocessor error pushes no error code.
// - Numeric op with emulate or switched bit, or wait with both monitor and switched bits, raises 7.
module protection_exception_unit (
   input  wire logic                           clk_i,         // 100 MHz clock
   input  wire logic                           rst_i,         // Sync reset, high
   input  wire logic [31:0]                    wb_adr_i,      // Wishbone address
   input  wire logic [31:0]                    wb_dat_i,      // Wishbone write data
   input  wire logic [3:0]                     wb_sel_i,      // Byte enables
   input  wire logic                           wb_we_i,       // Write enable
   input  wire logic                           wb_cyc_i,      // Cycle
   input  wire logic                           wb_stb_i,      // Strobe
   output logic      [31:0]                    wb_dat_o,      // Read data
   output logic                                wb_ack_o,      // Acknowledge
   input  wire logic                           ref_valid_i,   // Reference checked
   input  wire logic [15:0]                    ref_offset_i,  // Reference offset
   input  wire logic [15:0]                    ref_limit_i,   // Segment limit
   input  wire logic                           ref_word_i,    // Word access
   input  wire logic                           ref_write_i,   // Write access
   input  wire logic                           ref_readonly_i,// Segment read only
   input  wire logic                           ref_stack_i,   // Through stack seg
   input  wire logic [15:0]                    ref_sel_i,     // Segment selector
   input  wire logic                           fault_valid_i, // Core-found fault
   input  wire prot_exc_pkg::fault_kind_type   fault_kind_i,  // Its kind
   input  wire logic                           fault_has_sel_i, // Selector known
   input  wire logic                           fault_desc_load_i, // Descriptor load
   input  wire logic [15:0]                    fault_sel_i,   // Offending selector
   input  wire logic                           fault_vectab_i,// Selector in vector table
   input  wire logic                           ext_event_i,   // Servicing external event
   input  wire prot_exc_pkg::numeric_kind_type num_kind_i,    // Numeric op class
   input  wire logic                           num_start_i,   // Numeric op starts
   input  wire logic                           coproc_error_n_i, // Error pin, low
   input  wire logic [15:0]                    flags_i,       // Flags to save
   input  wire logic [15:0]                    ret_cs_i,      // Return code segment
   input  wire logic [15:0]                    ret_ip_i,      // Return offset
   input  wire logic [15:0]                    handler_sp_i,  // Handler stack pointer
   input  wire logic                           push_ready_i,  // Stack write done
   output logic                                push_o,        // Stack write request
   output logic      [15:0]                    push_addr_o,   // Stack write offset
   output logic      [15:0]                    push_data_o,   // Stack write data
   output logic                                enter_o,       // Handler entry pulse
   output logic      [7:0]                     vector_o,      // Handler vector
   output logic                                busy_o         // Entry in progress
);
   import prot_exc_pkg::*;

   exc_state_type state_q;
   logic [31:0]   ctl_q;
   logic [15:0]   code_q;
   logic [15:0]   last_code_q;
   logic [15:0]   count_q;
   logic [15:0]   sp_q;
   logic [7:0]    vec_q;
   logic          has_code_q;
   logic [15:0]   ret_cs_q;
   logic [15:0]   ret_ip_q;
   logic [15:0]   flags_q;
   logic          err_meta_q;
   logic          err_sync_q;

   logic          prot_on;
   logic          emu_bit;
   logic          tsw_bit;
   logic          mon_bit;
   logic          chk_fault;
   logic          null_fault;
   logic          real_fault;
   logic          gp_fault;
   logic          num_unavail;
   logic          num_error;
   logic          raise;
   logic [7:0]    vec_d;
   logic          has_code_d;
   logic [15:0]   code_d;
   logic          bus_req;

   assign prot_on = ctl_q[`CTL_PROT_BIT];
   assign emu_bit = ctl_q[`CTL_EMU_BIT];
   assign tsw_bit = ctl_q[`CTL_TSW_BIT];
   assign mon_bit = ctl_q[`CTL_MON_BIT];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Selector error code with external bit folded in
   function automatic logic [15:0] sel_code(input logic [15:0] sel, input logic vt,
                                            input logic ext);
      logic [15:0] c;
      c = {sel[15:`ERR_INDEX_LSB], sel[`ERR_LOCAL_BIT], 2'b00};
      c[`ERR_VECTAB_BIT] = vt;
      c[`ERR_EXT_BIT] = ext;
      return c;
   endfunction

   // Pin passes two flops before use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_meta_q <= 1'b0;
         err_sync_q <= 1'b0;
      end else begin
         err_meta_q <= !coproc_error_n_i;
         err_sync_q <= err_meta_q;
      end
   end

   always_comb begin
      chk_fault = prot_on && ref_valid_i &&
                  ((ref_offset_i > ref_limit_i) ||
                   (ref_word_i && (ref_offset_i == ref_limit_i)) ||
                   (ref_write_i && ref_readonly_i));
      null_fault = prot_on && ref_valid_i && !ref_stack_i &&
                   (ref_sel_i <= `NULL_SEL_MAX);
      real_fault = !prot_on && ref_valid_i && ref_word_i &&
                   (ref_offset_i == `REAL_WORD_LAST_OFS);
      gp_fault = chk_fault || null_fault || real_fault;
      num_unavail = num_start_i &&
                    (((num_kind_i != NUM_WAIT) && (num_kind_i != NUM_NONE) &&
                      (emu_bit || tsw_bit)) ||
                     ((num_kind_i == NUM_WAIT) && mon_bit && tsw_bit));
      // error line sampled, control ops skip it
      num_error = num_start_i && err_sync_q &&
                  ((num_kind_i == NUM_TESTING) || ((num_kind_i == NUM_WAIT) && !emu_bit));
      raise = fault_valid_i || gp_fault || num_unavail || num_error;
      vec_d = `VEC_GEN_PROT;
      has_code_d = 1'b1;
      code_d = `ERR_CODE_ZERO;
      if (fault_valid_i) begin
         case (fault_kind_i)
            FAULT_UNDEF: begin
               vec_d = `VEC_UNDEF_OPCODE;
               has_code_d = 1'b0;
            end
            FAULT_OVERRUN: begin
               vec_d = `VEC_COPROC_OVERRUN;
               has_code_d = 1'b0;
            end
            FAULT_TASK_STATE: vec_d = `VEC_BAD_TASK_STATE;
            FAULT_ABSENT:     vec_d = `VEC_SEG_ABSENT;
            FAULT_STACK:      vec_d = `VEC_STACK_FAULT;
            default:          vec_d = `VEC_GEN_PROT;
         endcase
         // selector only on descriptor loads for 13
         if (fault_has_sel_i && (vec_d != `VEC_GEN_PROT || fault_desc_load_i)) begin
            code_d = sel_code(fault_sel_i, fault_vectab_i, ext_event_i);
         end
      end else if (gp_fault) begin
         vec_d = `VEC_GEN_PROT;
      end else if (num_unavail) begin
         vec_d = `VEC_COPROC_UNAVAIL;
         has_code_d = 1'b0;
      end else begin
         vec_d = `VEC_COPROC_ERROR;
         has_code_d = 1'b0;
      end
   end

   // Entry sequence; busy_o stalls the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q    <= ST_IDLE;
         vec_q      <= 8'h00;
         code_q     <= 16'h0000;
         has_code_q <= 1'b0;
         sp_q       <= 16'h0000;
         ret_cs_q   <= 16'h0000;
         ret_ip_q   <= 16'h0000;
         flags_q    <= 16'h0000;
         push_o     <= 1'b0;
         push_addr_o <= 16'h0000;
         push_data_o <= 16'h0000;
         enter_o    <= 1'b0;
         vector_o   <= 8'h00;
         busy_o     <= 1'b0;
      end else begin
         enter_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // handler body faults take ordinary path
               if (raise) begin
                  vec_q      <= vec_d;
                  code_q     <= code_d;
                  has_code_q <= has_code_d;
                  sp_q       <= handler_sp_i - 16'h0002;
                  ret_cs_q   <= ret_cs_i;
                  ret_ip_q   <= ret_ip_i;
                  flags_q    <= flags_i;
                  busy_o     <= 1'b1;
                  push_o     <= 1'b1;
                  push_addr_o <= handler_sp_i - 16'h0002;
                  push_data_o <= flags_i;
                  state_q    <= ST_PUSH_FL;
               end
            end
            ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP, ST_PUSH_ERR: begin
               // fault during entry becomes nested fault
               if (fault_valid_i && vec_q != `VEC_NESTED) begin
                  vec_q      <= `VEC_NESTED;
                  code_q     <= `ERR_CODE_ZERO;
                  has_code_q <= 1'b1;
                  sp_q       <= handler_sp_i - 16'h0002;
                  push_o     <= 1'b1;
                  push_addr_o <= handler_sp_i - 16'h0002;
                  push_data_o <= flags_q;
                  state_q    <= ST_PUSH_FL;
               end else if (push_ready_i) begin
                  sp_q <= sp_q - 16'h0002;
                  push_addr_o <= sp_q - 16'h0002;
                  case (state_q)
                     ST_PUSH_FL: begin
                        push_data_o <= ret_cs_q;
                        state_q <= ST_PUSH_CS;
                     end
                     ST_PUSH_CS: begin
                        push_data_o <= ret_ip_q;
                        state_q <= ST_PUSH_IP;
                     end
                     ST_PUSH_IP: begin
                        push_data_o <= code_q;
                        push_o  <= has_code_q;
                        state_q <= has_code_q ? ST_PUSH_ERR : ST_ENTER;
                     end
                     default: begin
                        push_o  <= 1'b0;
                        state_q <= ST_ENTER;
                     end
                  endcase
               end
            end
            ST_ENTER: begin
               push_o   <= 1'b0;
               enter_o  <= 1'b1;
               vector_o <= vec_q;
               busy_o   <= 1'b0;
               state_q  <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Statistics
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_code_q <= 16'h0000;
         count_q     <= 16'h0000;
      end else if (state_q == ST_ENTER) begin
         last_code_q <= has_code_q ? code_q : 16'h0000;
         count_q     <= count_q + 16'h0001;
      end
   end

   // Wishbone slave, registered ack one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q    <= `CONTROL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && wb_we_i && wb_adr_i == `REG_CONTROL) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) begin
                  ctl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
               end
            end
         end
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               `REG_CONTROL:     wb_dat_o <= ctl_q;
               `REG_STATUS:      wb_dat_o <= {16'h0000, vec_q, 3'b000, err_sync_q,
                                              1'b0, state_q};
               `REG_LAST_CODE:   wb_dat_o <= {16'h0000, last_code_q};
               `REG_FAULT_COUNT: wb_dat_o <= {16'h0000, count_q};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
